// *** rtl/uib_cfg.svh ***
// uib_cfg.svh: offsets, field positions and reset values of the serial port register set
// assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register
`ifndef UIB_CFG_SVH
`define UIB_CFG_SVH
`define UIB_A_FIFO 8'h00
`define UIB_A_RAW 8'h04
`define UIB_A_MST 8'h08
`define UIB_A_ENA 8'h0C
`define UIB_A_CLR 8'h10
`define UIB_A_DIV 8'h14
`define UIB_A_ABD 8'h18
`define UIB_A_CF0 8'h20
`define UIB_A_CF1 8'h24
`define UIB_A_EDGE 8'h30
`define UIB_DIV_MASK 32'h00FF_FFFF
`define UIB_DIV_RST 32'h0000_0010
`define UIB_DIV_FRAC_LSB 20
`define UIB_ABD_MASK 32'h0000_FF01
`define UIB_ABD_RST 32'h0000_1000
`define UIB_ABD_EN_BIT 0
`define UIB_ABD_FILT_LSB 8
`define UIB_CF0_MASK 32'h0800_0000
`define UIB_CF0_RST 32'h0800_0000
`define UIB_CF0_CLKSEL_BIT 27
`define UIB_CF1_MASK 32'h07FF_07FF
`define UIB_CF1_RST 32'h0060_0060
`define UIB_CF1_TXE_LSB 16
`define UIB_IRQ_RXF 0
`define UIB_IRQ_TXE 1
`define UIB_RESP_OKAY 2'h0
`define UIB_RESP_SLVERR 2'h2
`endif

// *** rtl/uib_pkg.sv ***
// uib_pkg: types shared by the serial port register block
// assumes the constants of uib_cfg.svh
package uib_pkg;
  // one bit per interrupt source, receive-full at bit 0 up to escape char at bit 18
  typedef logic [18:0] uib_irq_t;
endpackage

// *** rtl/uib_regs.sv ***
// uib_regs: AXI4-Lite register block of a serial port: rx data port, interrupts, baud divider, autobaud filter
// assumes event inputs are one-cycle pulses and all inputs are synchronous to clk_i
//
// Overview of operation
// - FIFO data read returns next receive byte
// - nineteen read-only raw interrupt status bits
// - masked status is raw and enable
// - read/write enable bit per source, same order
// - clear register write-one clears raw bit
// - divider integer part sets whole divisor
// - fractional part adds fraction to divisor
// - autobaud ignores pulses shorter than filter value
// - autobaud measures only while enable set
// - clock select one pclk, zero reference tick
// - tx count below threshold sets tx-empty
// - rx count above threshold sets rx-full
`timescale 1ns/100ps
`default_nettype none
`include "uib_cfg.svh"
module uib_regs #(
  parameter int DIV_INT_W = 20,
  parameter int DIV_FRAC_W = 4,
  parameter int FILT_W = 8,
  parameter int CNT_W = 11
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_pop_o,
  input wire logic [18:2] event_i,
  input wire logic [CNT_W-1:0] tx_count_i,
  input wire logic [CNT_W-1:0] rx_count_i,
  input wire logic ref_tick_i,
  input wire logic rxd_i,
  output logic baud_tick_o,
  output logic rxd_filt_o,
  output logic irq_o
);
  // the fraction field starts at a fixed bit, so the integer part may not grow into it
  if (DIV_INT_W < 1 || DIV_INT_W > `UIB_DIV_FRAC_LSB || DIV_FRAC_W < 1 || DIV_FRAC_W > 4 || CNT_W < 1 || CNT_W > 11
      || FILT_W < 1 || FILT_W > 8) begin : g_chk
    $error("uib_regs: field widths exceed register layout");
  end

  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg, rx_pop_reg;
  logic [7:0] awaddr_reg, raddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] div_reg, abd_reg, cf0_reg, cf1_reg;
  uib_pkg::uib_irq_t raw_reg, ena_reg, irq_set, irq_clr, masked;
  logic wr_do, ar_do, wr_hit;
  logic [31:0] wmask;
  logic [DIV_INT_W-1:0] bcnt_reg, div_int;
  logic [DIV_FRAC_W-1:0] facc_reg, div_frac;
  logic [DIV_FRAC_W:0] facc_sum;
  logic extra_reg, tick_en, bit_end, bit_tick_reg;
  logic [FILT_W-1:0] run_reg, min_pulse_width;
  logic filt_reg, autobaud_en;
  logic [15:0] edge_reg;
  logic [CNT_W-1:0] txe_thr, rxf_thr;

  // write address and data are taken in either order; the response waits for both
  assign s_axi_awready_o = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_hold_reg && !bvalid_reg;
  assign wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wmask[8*b+:8] = {8{wstrb_reg[b]}};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end else if (wr_do) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end else if (wr_do) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // decode of writable offsets; anything else answers SLVERR and changes nothing
  always_comb begin
    unique case (awaddr_reg)
      `UIB_A_ENA, `UIB_A_CLR, `UIB_A_DIV, `UIB_A_ABD, `UIB_A_CF0, `UIB_A_CF1: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `UIB_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `UIB_RESP_OKAY : `UIB_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read/write configuration words, byte strobes honoured, reserved bits kept zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ena_reg <= '0;
      div_reg <= `UIB_DIV_RST;
      abd_reg <= `UIB_ABD_RST;
      cf0_reg <= `UIB_CF0_RST;
      cf1_reg <= `UIB_CF1_RST;
    end else if (wr_do) begin
      unique case (awaddr_reg)
        `UIB_A_ENA: ena_reg <= (ena_reg & ~wmask[18:0]) | (wdata_reg[18:0] & wmask[18:0]);
        `UIB_A_DIV: div_reg <= ((div_reg & ~wmask) | (wdata_reg & wmask)) & `UIB_DIV_MASK;
        `UIB_A_ABD: abd_reg <= ((abd_reg & ~wmask) | (wdata_reg & wmask)) & `UIB_ABD_MASK;
        `UIB_A_CF0: cf0_reg <= ((cf0_reg & ~wmask) | (wdata_reg & wmask)) & `UIB_CF0_MASK;
        `UIB_A_CF1: cf1_reg <= ((cf1_reg & ~wmask) | (wdata_reg & wmask)) & `UIB_CF1_MASK;
        default: ;
      endcase
    end
  end

  // interrupt sources: pulses from the transceiver plus two fifo level compares
  assign txe_thr = cf1_reg[`UIB_CF1_TXE_LSB +: CNT_W];
  assign rxf_thr = cf1_reg[CNT_W-1:0];
  always_comb begin
    irq_set = '0;
    irq_set[18:2] = event_i;
    irq_set[`UIB_IRQ_TXE] = tx_count_i < txe_thr;
    irq_set[`UIB_IRQ_RXF] = rx_count_i > rxf_thr;
  end
  assign irq_clr = (wr_do && awaddr_reg == `UIB_A_CLR) ? (wdata_reg[18:0] & wmask[18:0]) : '0;

  // sticky raw bits; a source firing in the clearing cycle stays set
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_reg <= '0;
    end else begin
      raw_reg <= (raw_reg & ~irq_clr) | irq_set;
    end
  end
  assign masked = raw_reg & ena_reg;
  assign irq_o = |masked;

  // read channel: one read in flight, data one cycle after the address is taken
  assign s_axi_arready_o = !rvalid_reg;
  assign ar_do = s_axi_arvalid_i && !rvalid_reg;
  assign rx_pop_o = ar_do && s_axi_araddr_i == `UIB_A_FIFO && rx_valid_i;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `UIB_RESP_OKAY;
      raddr_reg <= 8'h00;
      rx_pop_reg <= 1'b0;
    end else if (ar_do) begin
      rvalid_reg <= 1'b1;
      raddr_reg <= s_axi_araddr_i;
      rx_pop_reg <= rx_pop_o;
      rresp_reg <= `UIB_RESP_OKAY;
      unique case (s_axi_araddr_i)
        `UIB_A_FIFO: rdata_reg <= {24'h000000, rx_valid_i ? rx_data_i : 8'h00};
        `UIB_A_RAW: rdata_reg <= {13'h0000, raw_reg};
        `UIB_A_MST: rdata_reg <= {13'h0000, masked};
        `UIB_A_ENA: rdata_reg <= {13'h0000, ena_reg};
        `UIB_A_CLR: rdata_reg <= 32'h0000_0000; // write-only reads zero
        `UIB_A_DIV: rdata_reg <= div_reg;
        `UIB_A_ABD: rdata_reg <= abd_reg;
        `UIB_A_CF0: rdata_reg <= cf0_reg;
        `UIB_A_CF1: rdata_reg <= cf1_reg;
        `UIB_A_EDGE: rdata_reg <= {16'h0000, edge_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `UIB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // fractional divider: bit period is int ticks of the selected clock (pclk or reference tick), plus one when the fraction accumulator carries
  assign div_int = div_reg[DIV_INT_W-1:0];
  assign div_frac = div_reg[`UIB_DIV_FRAC_LSB +: DIV_FRAC_W];
  assign tick_en = cf0_reg[`UIB_CF0_CLKSEL_BIT] ? 1'b1 : ref_tick_i;
  assign bit_end = tick_en && div_int != '0 && bcnt_reg >= div_int - 1'b1 + DIV_INT_W'(extra_reg);
  assign facc_sum = {1'b0, facc_reg} + {1'b0, div_frac};
  assign baud_tick_o = bit_tick_reg;
  // a zero integer part stops the divider instead of ticking every cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bcnt_reg <= '0;
      facc_reg <= '0;
      extra_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end else begin
      bit_tick_reg <= bit_end;
      if (bit_end) begin
        bcnt_reg <= '0;
        facc_reg <= facc_sum[DIV_FRAC_W-1:0];
        extra_reg <= facc_sum[DIV_FRAC_W];
      end else if (tick_en && div_int != '0) begin
        bcnt_reg <= bcnt_reg + 1'b1;
      end
    end
  end

  // autobaud glitch filter: a new level is accepted only after it has stood long enough
  assign autobaud_en = abd_reg[`UIB_ABD_EN_BIT];
  assign min_pulse_width = abd_reg[`UIB_ABD_FILT_LSB +: FILT_W];
  assign rxd_filt_o = filt_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_reg <= 1'b1;
      run_reg <= '0;
      edge_reg <= 16'h0000;
    end else if (!autobaud_en) begin
      run_reg <= '0;
    end else if (rxd_i == filt_reg) begin
      run_reg <= '0;
    end else if (run_reg + 1'b1 >= min_pulse_width) begin
      filt_reg <= rxd_i;
      run_reg <= '0;
      edge_reg <= edge_reg + 16'h0001;
    end else begin
      run_reg <= run_reg + 1'b1;
    end
  end

  // checks of the behaviour above
  sequence s_fifo_read;
    rx_pop_o ##1 s_axi_rvalid_o;
  endsequence
  sequence s_clr_write;
    wr_do && awaddr_reg == `UIB_A_CLR;
  endsequence

  a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_o == |(raw_reg & ena_reg)) else $error("irq level differs from masked status");
  a_masked_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ar_do && s_axi_araddr_i == `UIB_A_MST |=> s_axi_rdata_o[18:0] == $past(raw_reg & ena_reg))
    else $error("masked status read wrong");
  a_raw_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_do && awaddr_reg == `UIB_A_CLR) |=> (($past(raw_reg) & ~raw_reg) == '0))
    else $error("raw bit dropped without clear");
  a_clear_w1c: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_clr_write |=> ((raw_reg & $past(irq_clr) & ~$past(irq_set)) == '0)) else $error("clear did not clear");
  a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_set != '0) |=> ((raw_reg & $past(irq_set)) == $past(irq_set))) else $error("event lost");
  a_txe_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_count_i < txe_thr |=> raw_reg[`UIB_IRQ_TXE]) else $error("tx empty not raised");
  a_rxf_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_count_i > rxf_thr |=> raw_reg[`UIB_IRQ_RXF]) else $error("rx full not raised");
  a_fifo_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_fifo_read |-> s_axi_rdata_o == {24'h000000, $past(rx_data_i)}) else $error("fifo byte wrong");
  a_fifo_empty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_axi_rvalid_o && raddr_reg == `UIB_A_FIFO && !rx_pop_reg |-> s_axi_rdata_o == 32'h0000_0000)
    else $error("empty fifo read not zero");
  a_ena_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_do && awaddr_reg == `UIB_A_ENA && wstrb_reg == 4'hF |=> ena_reg == $past(wdata_reg[18:0]))
    else $error("enable write lost");
  a_filter_short: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    filt_reg != $past(filt_reg) |-> $past(run_reg) + 1'b1 >= $past(min_pulse_width))
    else $error("short pulse passed filter");
  a_ab_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !autobaud_en |=> $stable(edge_reg) && $stable(filt_reg)) else $error("autobaud ran while off");
  a_ref_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cf0_reg[`UIB_CF0_CLKSEL_BIT] && !ref_tick_i |=> $stable(bcnt_reg)) else $error("divider ran without tick");
  a_bit_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bit_end |=> bcnt_reg == '0 && baud_tick_o) else $error("divider period wrong");
endmodule // uib_regs
`default_nettype wire

// *** verification/uib_remote_model.sv ***
// uib_remote_model: far-side serial device driving the receive line
// assumes the bench calls low_pulse between frames; the line idles high
`timescale 1ns/100ps
`default_nettype none
module uib_remote_model (
  input wire logic clk_i,
  output logic rxd_o
);
  // idle mark level until a pulse is asked for
  initial begin
    rxd_o = 1'b1;
  end
  // low pulse of n cycles, then idle 20 cycles, long enough for a filter of up to 20 cycles to settle
  task automatic low_pulse(input int n);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (20) @(posedge clk_i);
  endtask
endmodule // uib_remote_model
`default_nettype wire

// *** verification/tb_uart_irq_baud_registers.sv ***
// tb_uart_irq_baud_registers: register-level tests of uib_regs over AXI4-Lite
// assumes uib_cfg.svh offsets and the remote model on the receive line
`timescale 1ns/100ps
`default_nettype none
`include "uib_cfg.svh"
module tb_uart_irq_baud_registers;
  logic clk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, rx_valid_i, rx_pop_o;
  logic ref_tick_i, rxd_i, baud_tick_o, rxd_filt_o, irq_o, ref_on;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, rx_data_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic [18:2] event_i;
  logic [10:0] tx_count_i, rx_count_i;
  int n_mismatch, num_checks, n_pop, n_tick, t0, n_flo;
  uib_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_pop_o(rx_pop_o),
    .event_i(event_i), .tx_count_i(tx_count_i), .rx_count_i(rx_count_i), .ref_tick_i(ref_tick_i),
    .rxd_i(rxd_i), .baud_tick_o(baud_tick_o), .rxd_filt_o(rxd_filt_o), .irq_o(irq_o));
  uib_remote_model remote (.clk_i(clk_i), .rxd_o(rxd_i));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // counted at the falling edge, where registered and combinational outputs have settled
  always @(negedge clk_i) begin
    if (baud_tick_o === 1'b1) n_tick++;
  end
  // pops and filtered-low cycles are counted the same way
  always @(negedge clk_i) begin
    if (rx_pop_o === 1'b1) n_pop++;
    if (rxd_filt_o === 1'b0) n_flo++;
  end
  // reference tick every other cycle while asked for, so the divider runs at half rate
  always @(posedge clk_i) begin
    ref_tick_i <= ref_on && !ref_tick_i;
  end
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // handshakes judged at the falling edge so the decision never races the rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ah = s_axi_awvalid_i && s_axi_awready_o;
      wh = s_axi_wvalid_i && s_axi_wready_o;
      bh = s_axi_bvalid_o;
      rsp = s_axi_bresp_o;
      @(posedge clk_i);
      if (ah) s_axi_awvalid_i <= 1'b0;
      if (wh) s_axi_wvalid_i <= 1'b0;
      if (bh) s_axi_bready_i <= 1'b0;
    end while (!bh);
  endtask
  task automatic axr(input logic [7:0] a);
    logic ah, rh;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ah = s_axi_arvalid_i && s_axi_arready_o;
      rh = s_axi_rvalid_o;
      rd = s_axi_rdata_o;
      rsp = s_axi_rresp_o;
      @(posedge clk_i);
      if (ah) s_axi_arvalid_i <= 1'b0;
      if (rh) s_axi_rready_i <= 1'b0;
    end while (!rh);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axw(a, d);
    chk($sformatf("bresp %h", a), {30'h0, rsp}, {30'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    axr(a);
    chk($sformatf("rdata %h", a), rd, exp);
    chk($sformatf("rresp %h", a), {30'h0, rsp}, {30'h0, er});
  endtask
  // any whole span of n cycles holds the same tick count once the period is regular
  task automatic ticks(input int n, input int exp);
    repeat (10) @(posedge clk_i);
    t0 = n_tick;
    repeat (n) @(posedge clk_i);
    chk("baud ticks", n_tick - t0, exp);
  endtask
  task automatic ck_irq(input logic exp);
    @(negedge clk_i);
    chk("irq", {31'h0, irq_o}, {31'h0, exp});
  endtask
  // watchdog: the sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, rx_valid_i} = '0;
    {rst_n_i, ref_on, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, rx_data_i, event_i} = '0;
    s_axi_wstrb_i = 4'hF;
    tx_count_i = 11'h100;
    rx_count_i = 11'h000;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc(`UIB_A_ENA, 32'h0000_0000, `UIB_RESP_OKAY);
    rdc(`UIB_A_DIV, `UIB_DIV_RST, `UIB_RESP_OKAY);
    rdc(`UIB_A_ABD, `UIB_ABD_RST, `UIB_RESP_OKAY);
    wrc(`UIB_A_DIV, 32'h0000_0004, `UIB_RESP_OKAY);
    ticks(40, 10);
    wrc(`UIB_A_DIV, 32'h0080_0004, `UIB_RESP_OKAY);
    rdc(`UIB_A_DIV, 32'h0080_0004, `UIB_RESP_OKAY);
    ticks(180, 40);
    wrc(`UIB_A_CF0, 32'h0000_0000, `UIB_RESP_OKAY);
    ticks(40, 0);
    ref_on <= 1'b1;
    repeat (20) @(posedge clk_i);
    ticks(360, 40);
    ref_on <= 1'b0;
    wrc(`UIB_A_CF0, `UIB_CF0_RST, `UIB_RESP_OKAY);
    ticks(180, 40);
    // only the low byte lane is written
    s_axi_wstrb_i <= 4'h1;
    wrc(`UIB_A_DIV, 32'hFFFF_FF08, `UIB_RESP_OKAY);
    s_axi_wstrb_i <= 4'hF;
    rdc(`UIB_A_DIV, 32'h0080_0008, `UIB_RESP_OKAY);
    // every event source at once, then gone again
    @(posedge clk_i);
    event_i <= 17'h1FFFF;
    @(posedge clk_i);
    event_i <= 17'h00000;
    rdc(`UIB_A_RAW, 32'h0007_FFFC, `UIB_RESP_OKAY);
    rdc(`UIB_A_MST, 32'h0000_0000, `UIB_RESP_OKAY);
    ck_irq(1'b0);
    wrc(`UIB_A_ENA, 32'h0007_FFFF, `UIB_RESP_OKAY);
    rdc(`UIB_A_ENA, 32'h0007_FFFF, `UIB_RESP_OKAY);
    ck_irq(1'b1);
    wrc(`UIB_A_ENA, 32'h0000_0004, `UIB_RESP_OKAY);
    rdc(`UIB_A_MST, 32'h0000_0004, `UIB_RESP_OKAY);
    wrc(`UIB_A_CLR, 32'h0000_0004, `UIB_RESP_OKAY);
    ck_irq(1'b0);
    wrc(`UIB_A_CLR, 32'h0000_0000, `UIB_RESP_OKAY);
    wrc(`UIB_A_RAW, 32'h0000_0000, `UIB_RESP_SLVERR);
    rdc(`UIB_A_RAW, 32'h0007_FFF8, `UIB_RESP_OKAY);
    tx_count_i <= 11'h05F;
    rx_count_i <= 11'h061;
    rdc(`UIB_A_RAW, 32'h0007_FFFB, `UIB_RESP_OKAY);
    tx_count_i <= 11'h060;
    rx_count_i <= 11'h060;
    wrc(`UIB_A_CLR, 32'h0007_FFFF, `UIB_RESP_OKAY);
    rdc(`UIB_A_RAW, 32'h0000_0000, `UIB_RESP_OKAY);
    // receive data port: empty, then one byte waiting
    rdc(`UIB_A_FIFO, 32'h0000_0000, `UIB_RESP_OKAY);
    rx_data_i <= 8'hA5;
    rx_valid_i <= 1'b1;
    rdc(`UIB_A_FIFO, 32'h0000_00A5, `UIB_RESP_OKAY);
    rx_valid_i <= 1'b0;
    chk("pops", n_pop, 1);
    wrc(`UIB_A_FIFO, 32'h0000_0000, `UIB_RESP_SLVERR);
    rdc(8'h3C, 32'h0000_0000, `UIB_RESP_SLVERR);
    // autobaud: filter of four cycles, a short glitch and a real low pulse
    wrc(`UIB_A_ABD, 32'h0000_0401, `UIB_RESP_OKAY);
    remote.low_pulse(2);
    remote.low_pulse(10);
    rdc(`UIB_A_EDGE, 32'h0000_0002, `UIB_RESP_OKAY);
    chk("filtered low cycles", n_flo, 10);
    wrc(`UIB_A_ABD, 32'h0000_0400, `UIB_RESP_OKAY);
    remote.low_pulse(10);
    rdc(`UIB_A_EDGE, 32'h0000_0002, `UIB_RESP_OKAY);
    chk("filtered low cycles", n_flo, 10);
    tally_and_finish();
  end
endmodule // tb_uart_irq_baud_registers
`default_nettype wire
